// ==== src/i2c_start_pkg.sv ====
/*
 * Shared constants of the two-wire start and bus-ownership control:
 * register offsets, bit positions, reset values, wait counts, states.
 * Assumes a byte-wide register port with three address bits.
 */
package i2c_start_pkg;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [2:0] CTRL_OFS   = 3'h0;
	localparam logic [2:0] STAT_OFS   = 3'h1;
	localparam logic [2:0] FLAG_OFS   = 3'h2;
	localparam logic [2:0] CLKSEL_OFS = 3'h3;
	localparam logic [2:0] CLKEXT_OFS = 3'h4;
	localparam logic [2:0] SHIFT_OFS  = 3'h5;
	localparam logic [2:0] SLVADR_OFS = 3'h6;

	// ****************************************************************
	// Bit positions
	// ****************************************************************
	localparam int CTL_EN    = 7;
	localparam int CTL_LEAVE = 6;
	localparam int CTL_SPIE  = 4;
	localparam int CTL_STT   = 1;
	localparam int CTL_SPT   = 0;
	localparam int ST_MST    = 7;
	localparam int ST_EXT    = 5;
	localparam int ST_COI    = 4;
	localparam int ST_STD    = 1;
	localparam int ST_SPD    = 0;
	localparam int FL_ACC    = 7;
	localparam int FL_BSY    = 6;
	localparam int FL_SEN    = 1;
	localparam int FL_RSV    = 0;
	localparam int CS_CLD    = 5;
	localparam int CS_DAD    = 4;
	localparam int CS_SMC    = 3;
	localparam int CS_HI     = 1;
	localparam int CS_LO     = 0;
	localparam int CX_CLX    = 0;

	// ****************************************************************
	// Reset values, codes and timing counts
	// ****************************************************************
	localparam logic [7:0] REG_RST   = 8'h00;
	localparam logic [3:0] EXT_LOW   = 4'h0;
	localparam logic [3:0] EXT_HIGH  = 4'hF;
	localparam logic [7:0] HALF_STD  = 8'h14;
	localparam logic [7:0] HALF_FAST = 8'h05;
	localparam logic [7:0] ACC_W00   = 8'h06;
	localparam logic [7:0] ACC_W01   = 8'h06;
	localparam logic [7:0] ACC_W10   = 8'h0C;
	localparam logic [7:0] ACC_W11   = 8'h03;

	// Pin sequencer states
	typedef enum logic [2:0] {
		GEN_IDLE    = 3'b000,
		GEN_STA_SDA = 3'b001,
		GEN_STA_SCL = 3'b010,
		GEN_WAIT    = 3'b011,
		GEN_STO_SDA = 3'b100,
		GEN_STO_SCL = 3'b101,
		GEN_STO_REL = 3'b110
	} gen_t;

endpackage : i2c_start_pkg

// ==== src/bus_lines_if.sv ====
/*
 * Carrier of the sampled bus line levels and the detected start and
 * stop events between the synchroniser, detector and controller.
 * Assumes all three parties run on sys_clk.
 */
`timescale 1ns/1ps
interface bus_lines_if;
	logic sclLvl;
	logic sdaLvl;
	logic startDet;
	logic stopDet;

	modport syncer   (output sclLvl, output sdaLvl);
	modport detector (input sclLvl, input sdaLvl,
	                  output startDet, output stopDet);
	modport ctrl     (input sclLvl, input sdaLvl,
	                  input startDet, input stopDet);
endinterface : bus_lines_if

// ==== src/pin_sync.sv ====
/*
 * Three-stage synchroniser for the clock and data pins; a level is
 * taken once the second and third stages agree.
 * Assumes pins are asynchronous to sys_clk and idle high.
 */
`timescale 1ns/1ps
module pin_sync (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// Raw pins, bit 1 clock, bit 0 data
	input  wire logic [1:0] pinRaw,
	// Filtered levels
	bus_lines_if.syncer     lines
);
	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
		logic [1:0] s3;
		logic [1:0] lvl;
	} sync_t;

	sync_t sync_r;
	sync_t sync_nxt;

	// Level changes only where stages two and three agree
	always_comb begin
		sync_nxt     = sync_r;
		sync_nxt.s1  = pinRaw;
		sync_nxt.s2  = sync_r.s1;
		sync_nxt.s3  = sync_r.s2;
		sync_nxt.lvl = (sync_r.s2 & ~(sync_r.s2 ^ sync_r.s3))
		             | (sync_r.lvl & (sync_r.s2 ^ sync_r.s3));
	end

	// Idle bus is high, so reset to ones
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sync_r <= '{s1: 2'h3, s2: 2'h3, s3: 2'h3, lvl: 2'h3};
		end else begin
			sync_r <= sync_nxt;
		end
	end

	assign lines.sclLvl = sync_r.lvl[1];
	assign lines.sdaLvl = sync_r.lvl[0];
endmodule : pin_sync

// ==== src/cond_detect.sv ====
/*
 * Start and stop condition detector on the filtered line levels.
 * Assumes levels come from pin_sync on the same clock.
 */
`timescale 1ns/1ps
module cond_detect (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// Levels in, events out
	bus_lines_if.detector lines
);
	typedef struct packed {
		logic prevScl;
		logic prevSda;
		logic start;
		logic stop;
	} det_t;

	det_t det_r;
	det_t det_nxt;

	// Data edge while clock stays high marks a condition
	always_comb begin
		det_nxt         = det_r;
		det_nxt.prevScl = lines.sclLvl;
		det_nxt.prevSda = lines.sdaLvl;
		det_nxt.start   = det_r.prevSda & ~lines.sdaLvl
		                & det_r.prevScl & lines.sclLvl;
		det_nxt.stop    = ~det_r.prevSda & lines.sdaLvl
		                & det_r.prevScl & lines.sclLvl;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			det_r <= '{prevScl: 1'b1, prevSda: 1'b1,
			           start: 1'b0, stop: 1'b0};
		end else begin
			det_r <= det_nxt;
		end
	end

	assign lines.startDet = det_r.start;
	assign lines.stopDet  = det_r.stop;
endmodule : cond_detect

// ==== src/i2c_start_ctrl.sv ====
/*
 * Start and bus-ownership control of a two-wire bus controller:
 * wakeup filter, start generation, reservation, stop generation.
 * Assumes an external byte engine supplies received addresses and
 * takes over after shiftLoad; pins are open drain.
 */
// Chosen here: the address-and-strobe port and the register addresses.
//
// Function
// - Slave interrupt only on match or extension
// - Start detection enters wakeup standby
// - Stop interrupt follows stop enable only
// - Free bus start request generates start, waits
// - Start if released, otherwise record reservation
// - Address after stop starts master; earlier ignored
// - Reservation accepted between start and stop
// - Reservation disabled: busy bus rejects start
// - Start accepted flag reports outcome after wait
// - Start enable zero: busy set at enable
// - Start enable one: busy cleared at enable
// - Reserved transfer waits for stop condition, with or without stop interrupt
`timescale 1ns/1ps
module i2c_start_ctrl (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// Register port
	input  wire logic [2:0] regAddr,
	input  wire logic [7:0] wrData,
	input  wire logic       wrStb,
	input  wire logic       rdStb,
	output logic      [7:0] rdData,
	// Bus pins, open drain
	input  wire logic       clockPinIn,
	output logic            clockPinOut,
	output logic            clockPinOe,
	input  wire logic       dataPinIn,
	output logic            dataPinOut,
	output logic            dataPinOe,
	// Byte engine side
	input  wire logic       addrValid,
	input  wire logic [7:0] rxAddr,
	output logic            shiftLoad,
	output logic      [7:0] shiftData,
	output logic            busEventIrq
);
	typedef struct packed {
		logic                 en;
		logic                 spie;
		logic                 stt;
		logic                 spt;
		logic                 mst;
		logic                 ext;
		logic                 coi;
		logic                 std;
		logic                 spd;
		logic                 stAcc;
		logic                 bsy;
		logic                 frEn;
		logic                 rsv;
		logic                 smc;
		logic                 hi;
		logic                 lo;
		logic                 clx;
		logic [6:0]           slvAdr;
		logic                 standby;
		logic                 resvPend;
		logic                 resvArmed;
		logic                 loadAfter;
		logic                 decide;
		logic [7:0]           decCnt;
		i2c_start_pkg::gen_t  gen;
		logic [7:0]           genCnt;
		logic                 irq;
		logic                 load;
		logic [7:0]           shData;
		logic [7:0]           rd;
	} ctrl_t;

	ctrl_t       s_r;
	ctrl_t       s_nxt;
	logic [7:0]  accWait;
	logic [7:0]  halfCnt;
	logic        ctlWr;
	logic        shWr;
	logic        addrMatch;
	logic        extCode;
	logic        genFree;
	logic        resolve;

	bus_lines_if lines ();

	// ****************************************************************
	// Line sampling and condition detection
	// ****************************************************************
	pin_sync u_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.pinRaw  ({clockPinIn, dataPinIn}),
		.lines   (lines.syncer)
	);

	cond_detect u_det (
		.sys_clk (sys_clk),
		.rst     (rst),
		.lines   (lines.detector)
	);

	// ****************************************************************
	// Decode helpers
	// ****************************************************************
	always_comb begin
		unique case ({s_r.hi, s_r.lo})
			2'b00: accWait = i2c_start_pkg::ACC_W00;
			2'b01: accWait = i2c_start_pkg::ACC_W01;
			2'b10: accWait = i2c_start_pkg::ACC_W10;
			2'b11: accWait = i2c_start_pkg::ACC_W11;
		endcase
	end

	// Fast mode cuts each line phase from 21 to 6 cycles; finer dividers live elsewhere
	assign halfCnt   = s_r.smc ? i2c_start_pkg::HALF_FAST
	                           : i2c_start_pkg::HALF_STD;
	assign ctlWr     = wrStb && (regAddr == i2c_start_pkg::CTRL_OFS);
	assign shWr      = wrStb && (regAddr == i2c_start_pkg::SHIFT_OFS);
	assign addrMatch = (rxAddr[7:1] == s_r.slvAdr);
	assign extCode   = (rxAddr[7:4] == i2c_start_pkg::EXT_LOW)
	                 || (rxAddr[7:4] == i2c_start_pkg::EXT_HIGH);
	assign genFree   = (s_r.gen == i2c_start_pkg::GEN_IDLE)
	                 || (s_r.gen == i2c_start_pkg::GEN_WAIT);
	assign resolve   = s_r.decide && (s_r.decCnt == 8'h01);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		s_nxt      = s_r;
		s_nxt.irq  = 1'b0;
		s_nxt.load = 1'b0;
		s_nxt.rd   = i2c_start_pkg::REG_RST;

		// Bus conditions seen on the lines
		if (s_r.en && lines.startDet) begin
			s_nxt.bsy     = 1'b1;
			s_nxt.std     = 1'b1;
			s_nxt.spd     = 1'b0;
			s_nxt.ext     = 1'b0;
			s_nxt.coi     = 1'b0;
			s_nxt.standby = 1'b1;
		end
		if (s_r.en && lines.stopDet) begin
			s_nxt.bsy     = 1'b0;
			s_nxt.spd     = 1'b1;
			s_nxt.std     = 1'b0;
			s_nxt.mst     = 1'b0;
			s_nxt.ext     = 1'b0;
			s_nxt.coi     = 1'b0;
			s_nxt.standby = 1'b0;
			s_nxt.irq     = s_r.spie;
			if (s_r.resvPend) begin
				s_nxt.resvPend  = 1'b0;
				s_nxt.resvArmed = 1'b1;
			end
		end

		// Wakeup filter: mismatching addresses stay silent unless extension code or master
		if (s_r.en && addrValid && s_r.standby) begin
			s_nxt.standby = 1'b0;
			s_nxt.coi     = addrMatch;
			s_nxt.ext     = extCode;
			if (addrMatch || extCode || s_r.mst) begin
				s_nxt.irq = 1'b1;
			end
		end

		// Start request: decide after the acceptance wait
		if (s_r.stt && !s_r.decide) begin
			s_nxt.decide = 1'b1;
			s_nxt.decCnt = accWait;
		end else if (s_r.decide) begin
			s_nxt.decCnt = s_r.decCnt - 8'h01;
		end
		if (resolve) begin
			s_nxt.decide = 1'b0;
			s_nxt.stt    = 1'b0;
			if (!s_r.bsy && genFree) begin
				s_nxt.stAcc     = 1'b1;
				s_nxt.mst       = 1'b1;
				s_nxt.loadAfter = 1'b0;
				s_nxt.gen       = i2c_start_pkg::GEN_STA_SDA;
				s_nxt.genCnt    = halfCnt;
			end else if (s_r.rsv || !s_r.std) begin
				s_nxt.stAcc = 1'b0;
			end else begin
				s_nxt.stAcc    = 1'b0;
				s_nxt.resvPend = 1'b1;
			end
		end

		// Shift register write: address of a reserved transfer, or a byte loaded after a start or while master
		if (shWr) begin
			if (s_r.resvArmed && !s_r.bsy && genFree) begin
				s_nxt.resvArmed = 1'b0;
				s_nxt.mst       = 1'b1;
				s_nxt.stAcc     = 1'b1;
				s_nxt.shData    = wrData;
				s_nxt.loadAfter = 1'b1;
				s_nxt.gen       = i2c_start_pkg::GEN_STA_SDA;
				s_nxt.genCnt    = halfCnt;
			end else if (s_r.gen == i2c_start_pkg::GEN_WAIT) begin
				s_nxt.shData = wrData;
				s_nxt.load   = 1'b1;
				s_nxt.gen    = i2c_start_pkg::GEN_IDLE;
			end else if (s_r.mst && s_r.gen == i2c_start_pkg::GEN_IDLE) begin
				s_nxt.shData = wrData;
				s_nxt.load   = 1'b1;
			end
		end

		// Stop request, also usable to free a bus held busy at enable
		if (s_r.spt && genFree && !s_r.decide) begin
			s_nxt.gen    = i2c_start_pkg::GEN_STO_SDA;
			s_nxt.genCnt = halfCnt;
		end

		// Pin sequencer
		if (s_r.gen != i2c_start_pkg::GEN_IDLE
		    && s_r.gen != i2c_start_pkg::GEN_WAIT) begin
			s_nxt.genCnt = s_r.genCnt - 8'h01;
		end
		if (s_r.genCnt == 8'h00) begin
			unique case (s_r.gen)
				i2c_start_pkg::GEN_STA_SDA: begin
					s_nxt.gen    = i2c_start_pkg::GEN_STA_SCL;
					s_nxt.genCnt = halfCnt;
				end
				i2c_start_pkg::GEN_STA_SCL: begin
					if (s_r.loadAfter) begin
						s_nxt.load = 1'b1;
						s_nxt.gen  = i2c_start_pkg::GEN_IDLE;
					end else begin
						s_nxt.gen = i2c_start_pkg::GEN_WAIT;
					end
				end
				i2c_start_pkg::GEN_STO_SDA: begin
					s_nxt.gen    = i2c_start_pkg::GEN_STO_SCL;
					s_nxt.genCnt = halfCnt;
				end
				i2c_start_pkg::GEN_STO_SCL: begin
					s_nxt.gen    = i2c_start_pkg::GEN_STO_REL;
					s_nxt.genCnt = halfCnt;
				end
				i2c_start_pkg::GEN_STO_REL: begin
					s_nxt.gen = i2c_start_pkg::GEN_IDLE;
					s_nxt.spt = 1'b0;
				end
				default: begin
				end
			endcase
		end

		// Register writes
		if (ctlWr) begin
			s_nxt.spie = wrData[i2c_start_pkg::CTL_SPIE];
			s_nxt.en   = wrData[i2c_start_pkg::CTL_EN];
			if (wrData[i2c_start_pkg::CTL_EN] && !s_r.en) begin
				s_nxt.bsy = !s_r.frEn;
			end
			// Repeat requests while one is pending are dropped
			if (s_r.en && wrData[i2c_start_pkg::CTL_STT] && !s_r.stt) begin
				s_nxt.stt = 1'b1;
			end
			if (s_r.en && wrData[i2c_start_pkg::CTL_SPT] && !s_r.spt) begin
				s_nxt.spt = 1'b1;
			end
			// Leaving drops participation and any wait hold
			if (s_r.en && wrData[i2c_start_pkg::CTL_LEAVE]) begin
				s_nxt.standby = 1'b0;
				s_nxt.ext     = 1'b0;
				s_nxt.coi     = 1'b0;
				if (s_r.gen == i2c_start_pkg::GEN_WAIT) begin
					s_nxt.gen = i2c_start_pkg::GEN_IDLE;
					s_nxt.mst = 1'b0;
				end
			end
			// Disabling clears every bus-side state except busy
			if (!wrData[i2c_start_pkg::CTL_EN]) begin
				s_nxt.stt       = 1'b0;
				s_nxt.spt       = 1'b0;
				s_nxt.mst       = 1'b0;
				s_nxt.ext       = 1'b0;
				s_nxt.coi       = 1'b0;
				s_nxt.std       = 1'b0;
				s_nxt.spd       = 1'b0;
				s_nxt.stAcc     = 1'b0;
				s_nxt.standby   = 1'b0;
				s_nxt.resvPend  = 1'b0;
				s_nxt.resvArmed = 1'b0;
				s_nxt.decide    = 1'b0;
				s_nxt.gen       = i2c_start_pkg::GEN_IDLE;
			end
		end
		if (wrStb && regAddr == i2c_start_pkg::FLAG_OFS) begin
			s_nxt.frEn = wrData[i2c_start_pkg::FL_SEN];
			s_nxt.rsv  = wrData[i2c_start_pkg::FL_RSV];
		end
		// Clock selection only lands while disabled
		if (wrStb && !s_r.en && regAddr == i2c_start_pkg::CLKSEL_OFS) begin
			s_nxt.smc = wrData[i2c_start_pkg::CS_SMC];
			s_nxt.hi  = wrData[i2c_start_pkg::CS_HI];
			s_nxt.lo  = wrData[i2c_start_pkg::CS_LO];
		end
		if (wrStb && !s_r.en && regAddr == i2c_start_pkg::CLKEXT_OFS) begin
			s_nxt.clx = wrData[i2c_start_pkg::CX_CLX];
		end
		if (wrStb && regAddr == i2c_start_pkg::SLVADR_OFS) begin
			s_nxt.slvAdr = wrData[7:1];
		end

		// Read data for the following cycle
		if (rdStb) begin
			unique case (regAddr)
				i2c_start_pkg::CTRL_OFS:
					s_nxt.rd = {s_r.en, 1'b0, 1'b0, s_r.spie,
					            2'b00, s_r.stt, s_r.spt};
				i2c_start_pkg::STAT_OFS:
					s_nxt.rd = {s_r.mst, 1'b0, s_r.ext, s_r.coi,
					            2'b00, s_r.std, s_r.spd};
				i2c_start_pkg::FLAG_OFS:
					s_nxt.rd = {s_r.stAcc, s_r.bsy, 4'h0,
					            s_r.frEn, s_r.rsv};
				i2c_start_pkg::CLKSEL_OFS:
					s_nxt.rd = {2'b00, lines.sclLvl, lines.sdaLvl,
					            s_r.smc, 1'b0, s_r.hi, s_r.lo};
				i2c_start_pkg::CLKEXT_OFS:
					s_nxt.rd = {7'h00, s_r.clx};
				i2c_start_pkg::SHIFT_OFS:
					s_nxt.rd = s_r.shData;
				i2c_start_pkg::SLVADR_OFS:
					s_nxt.rd = {s_r.slvAdr, 1'b0};
				default:
					s_nxt.rd = i2c_start_pkg::REG_RST;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************************************************************
	// Outputs: lines pulled low only, decoded from the sequencer
	// ****************************************************************
	assign rdData      = s_r.rd;
	assign shiftLoad   = s_r.load;
	assign shiftData   = s_r.shData;
	assign busEventIrq = s_r.irq;
	assign clockPinOut = 1'b0;
	assign dataPinOut  = 1'b0;
	assign clockPinOe  = (s_r.gen == i2c_start_pkg::GEN_STA_SCL)
	                   || (s_r.gen == i2c_start_pkg::GEN_WAIT)
	                   || (s_r.gen == i2c_start_pkg::GEN_STO_SDA);
	assign dataPinOe   = (s_r.gen != i2c_start_pkg::GEN_IDLE)
	                   && (s_r.gen != i2c_start_pkg::GEN_STO_REL);

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	mismatch_quiet_a: assert property (
		s_r.en && addrValid && s_r.standby && !addrMatch && !extCode
		&& !s_r.mst && !lines.stopDet |=> !busEventIrq)
		else $error("irq raised on address mismatch");
	start_standby_a: assert property (
		s_r.en && lines.startDet && !ctlWr |=> s_r.standby && s_r.bsy)
		else $error("start did not enter standby");
	stop_irq_a: assert property (
		s_r.en && lines.stopDet && !ctlWr
		|=> busEventIrq == $past(s_r.spie))
		else $error("stop irq not per enable bit");
	start_wait_a: assert property (
		resolve && !s_r.bsy && genFree && !wrStb
		|=> s_r.gen == i2c_start_pkg::GEN_STA_SDA && s_r.mst ##1
		(s_r.gen == i2c_start_pkg::GEN_STA_SDA)[*4])
		else $error("free bus start not generated");
	early_shift_a: assert property (
		shWr && s_r.resvPend && !s_r.mst |=> !shiftLoad
		&& s_r.gen == $past(s_r.gen))
		else $error("shift write before stop not ignored");
	reserve_a: assert property (
		resolve && s_r.bsy && !s_r.rsv && s_r.std && !ctlWr
		|=> s_r.resvPend && !s_r.stAcc)
		else $error("reservation not recorded");
	reject_a: assert property (
		resolve && s_r.bsy && s_r.rsv && !ctlWr
		|=> !s_r.stAcc && !s_r.resvPend && !s_r.stt)
		else $error("busy start not rejected");
	accept_wait_a: assert property (
		@(posedge sys_clk) disable iff (rst || !s_r.en)
		$rose(s_r.decide) && {s_r.hi, s_r.lo} == 2'b11
		|-> s_r.decide[*3] ##1 !s_r.decide)
		else $error("accept wait wrong length");
	enable_busy_a: assert property (
		ctlWr && wrData[i2c_start_pkg::CTL_EN] && !s_r.en && !s_r.frEn
		|=> s_r.bsy)
		else $error("busy not set at enable");
	enable_free_a: assert property (
		ctlWr && wrData[i2c_start_pkg::CTL_EN] && !s_r.en && s_r.frEn
		|=> !s_r.bsy)
		else $error("busy not cleared at enable");
	stop_free_a: assert property (
		s_r.en && lines.stopDet && !ctlWr |=> !s_r.bsy && s_r.spd)
		else $error("stop did not free bus");

	start_gen_c: cover property (s_r.gen == i2c_start_pkg::GEN_WAIT);
	resv_arm_c: cover property ($rose(s_r.resvArmed));
	reject_c: cover property (resolve && s_r.bsy && s_r.rsv);
	match_c: cover property (addrValid && s_r.standby && addrMatch);
endmodule : i2c_start_ctrl

// ==== testbench/bus_partner.sv ====
/*
 * Behavioural model of another party on the shared two-wire bus:
 * makes start and stop conditions and a short frame of clock pulses.
 * Assumes open-drain lines with pull-ups resolved by the bench.
 */
`timescale 1ns/1ps
module bus_partner (
	// Pull-low drives, high pulls the line low
	output logic      pScl,
	output logic      pSda,
	// Resolved line levels
	input  wire logic sclW,
	input  wire logic sdaW
);
	// ************************************************************
	// Frame generation
	// ************************************************************
	initial begin
		pScl = 1'b0;
		pSda = 1'b0;
	end

	// Start, then a frame of four 100 ns clock pulses with data held low
	task automatic doStart;
		wait (sclW && sdaW);
		#7 pSda = 1'b1;
		#100 pScl = 1'b1;
		repeat (4) begin
			#100 pScl = 1'b0;
			#100 pScl = 1'b1;
		end
	endtask : doStart

	// Stop: clock released first, then data rises; lines fall to pull-up
	task automatic doStop;
		#7 pScl = 1'b0;
		#100 pSda = 1'b0;
		#100;
	endtask : doStop
endmodule : bus_partner

// ==== testbench/i2c_wakeup_and_start_reservation_bench.sv ====
/*
 * Self-checking bench of the start and reservation control.
 * Assumes the partner model on the bus and byte-engine pulses here.
 */
`timescale 1ns/1ps
module i2c_wakeup_and_start_reservation_bench;
	localparam logic [2:0] CT = i2c_start_pkg::CTRL_OFS;
	localparam logic [2:0] ST = i2c_start_pkg::STAT_OFS;
	localparam logic [2:0] FL = i2c_start_pkg::FLAG_OFS;
	localparam logic [2:0] CS = i2c_start_pkg::CLKSEL_OFS;
	localparam logic [2:0] SH = i2c_start_pkg::SHIFT_OFS;
	localparam logic [2:0] CX = i2c_start_pkg::CLKEXT_OFS;
	logic       sys_clk, rst, wrStb, rdStb, addrValid;
	logic [2:0] regAddr;
	logic [7:0] wrData, rxAddr, rdData, shiftData, v;
	logic       cOe, cOut, dOe, dOut, shiftLoad, busEventIrq;
	logic       pScl, pSda;
	int         err_total, checks_done, irqN, ldN, cyc;
	// Open-drain lines with pull-ups
	wire logic  sclW = ~(cOe | pScl);
	wire logic  sdaW = ~(dOe | pSda);

	i2c_start_ctrl dut (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
		.wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
		.clockPinIn(sclW), .clockPinOut(cOut), .clockPinOe(cOe),
		.dataPinIn(sdaW), .dataPinOut(dOut), .dataPinOe(dOe),
		.addrValid(addrValid), .rxAddr(rxAddr), .shiftLoad(shiftLoad),
		.shiftData(shiftData), .busEventIrq(busEventIrq));
	bus_partner p (.pScl(pScl), .pSda(pSda), .sclW(sclW), .sdaW(sdaW));

	// ************************************************************
	// Clock, pulse counters and hang guard
	// ************************************************************
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// Pulses last one cycle, so they are counted rather than sampled
	always @(posedge sys_clk) begin
		cyc++;
		if (busEventIrq === 1'b1) irqN++;
		if (shiftLoad === 1'b1) ldN++;
		if (cyc == 20000) begin
			err_total++;
			give_verdict();
		end
	end

	// ************************************************************
	// Access tasks
	// ************************************************************
	task automatic chk(input string nm, input logic [7:0] s, e);
		checks_done++;
		if (s !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		wrData  <= d;
		wrStb   <= 1'b1;
		@(posedge sys_clk);
		wrStb   <= 1'b0;
	endtask : wr

	// Data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a);
		@(posedge sys_clk);
		regAddr <= a;
		rdStb   <= 1'b1;
		@(posedge sys_clk);
		rdStb   <= 1'b0;
		#1 v = rdData;
	endtask : rd

	task automatic av(input logic [7:0] a);
		@(posedge sys_clk);
		addrValid <= 1'b1;
		rxAddr    <= a;
		@(posedge sys_clk);
		addrValid <= 1'b0;
	endtask : av

	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : wt

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict

	// ************************************************************
	// Test sequence
	// ************************************************************
	initial begin
		{rst, wrStb, rdStb, addrValid} = 4'b1000;
		{regAddr, wrData, rxAddr} = '0;
		wt(16);
		rst <= 1'b0;
		wt(8);
		// Reset values, unmapped index, enable with busy assumed
		rd(CT); chk("ctrl", v, 8'h00);
		rd(FL); chk("flag", v, 8'h00);
		wr(i2c_start_pkg::SLVADR_OFS, 8'hA4);
		wr(CT, 8'h80);
		rd(FL); chk("busy", v, 8'h40);
		wr(CS, 8'h0B);
		rd(CS); chk("clksel", v, 8'h30);
		wr(3'h7, 8'hFF);
		rd(3'h7); chk("unmapped", v, 8'h00);
		// Disabled: fast clock, extension, bus free at enable
		wr(CT, 8'h00);
		wr(CS, 8'h0B);
		wr(CX, 8'h01);
		wr(FL, 8'h02);
		wr(CT, 8'h80);
		rd(CS); chk("clksel2", v, 8'h3B);
		rd(CX); chk("clkext", v, 8'h01);
		rd(FL); chk("free0", v, 8'h02);
		$display("test reset done");
		// Reservation disabled, bus busy: start refused
		wr(FL, 8'h01);
		wr(CT, 8'h00);
		wr(CT, 8'h80);
		wr(CT, 8'h82);
		wt(20);
		rd(FL); chk("acc0", v, 8'h41);
		rd(ST); chk("mst0", v & 8'h80, 8'h00);
		// Stop releases the bus, no irq with stop irq off
		wr(CT, 8'h81);
		wt(120);
		rd(FL); chk("free", v, 8'h01);
		rd(ST); chk("spd", v & 8'h81, 8'h01);
		chk("noirq", irqN[7:0], 8'h00);
		$display("test refuse done");
		// Free bus: start generated, then wait until shift write
		wr(CT, 8'h82);
		wt(8);
		rd(FL); chk("acc1", v & 8'h80, 8'h80);
		rd(ST); chk("mst1", v & 8'h80, 8'h80);
		wt(60);
		chk("wait", {4'h0, cOut, dOut, cOe, dOe}, 8'h03);
		wr(SH, 8'hA5);
		wt(5);
		chk("load", ldN[7:0], 8'h01);
		chk("sdata", shiftData, 8'hA5);
		wr(CT, 8'h81);
		wt(150);
		$display("test start done");
		// Reservation while the partner owns the bus
		wr(FL, 8'h00);
		wr(CT, 8'h90);
		p.doStart();
		rd(ST); chk("std", v & 8'h02, 8'h02);
		wr(CT, 8'h92);
		wt(20);
		rd(ST); chk("resv", v & 8'h80, 8'h00);
		wr(SH, 8'h11);
		wt(30);
		chk("early", ldN[7:0], 8'h01);
		p.doStop();
		wt(20);
		chk("stopirq", irqN[7:0], 8'h01);
		rd(ST); chk("spd2", v & 8'h81, 8'h01);
		wr(SH, 8'h3C);
		wt(100);
		chk("resload", ldN[7:0], 8'h02);
		chk("resdata", shiftData, 8'h3C);
		wr(CT, 8'h91);
		wt(150);
		$display("test reserve done");
		// Wakeup filter: mismatch silent until the next start
		p.doStart();
		av(8'h52);
		wt(3);
		chk("nomatch", irqN[7:0], 8'h02);
		p.doStop();
		p.doStart();
		av(8'hA5);
		wt(3);
		chk("match", irqN[7:0], 8'h04);
		rd(ST); chk("coi", v & 8'h10, 8'h10);
		wr(CT, 8'hD0);
		rd(ST); chk("left", v & 8'h30, 8'h00);
		p.doStop();
		wt(20);
		chk("stop", irqN[7:0], 8'h05);
		$display("test wakeup done");
		give_verdict();
	end
endmodule : i2c_wakeup_and_start_reservation_bench
